/* rtl/abp_pkg.sv */
package abp_pkg;

  // Register offsets
  localparam logic [7:0] OFF_BREAK_STATUS_CONTROL     = 8'h00;
  localparam logic [7:0] OFF_BREAK_ADDRESS_HIGH       = 8'h01;
  localparam logic [7:0] OFF_BREAK_ADDRESS_LOW        = 8'h02;
  localparam logic [7:0] OFF_BREAK_WAKE_STATUS        = 8'h03;
  localparam logic [7:0] OFF_BREAK_FLAG_CLEAR_CONTROL = 8'h04;
  localparam logic [7:0] OFF_IRQ_STATUS               = 8'h05;
  localparam logic [7:0] OFF_IRQ_MASK                 = 8'h06;

  // Field positions
  localparam int BIT_BREAK_ENABLE   = 7;
  localparam int BIT_BREAK_ACTIVE   = 6;
  localparam int BIT_BREAK_WAIT     = 1;
  localparam int BIT_STOP_WAIT_EXIT = 0;
  localparam int BIT_CLEAR_FLAGS_EN = 7;
  localparam int BIT_EV_MATCH       = 0;
  localparam int BIT_EV_SOFTWARE    = 1;
  localparam int BIT_EV_WAKE        = 2;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_IRQ  = 3'h0;

  // Break vectors
  localparam logic [15:0] VEC_USER    = 16'hFFFC;
  localparam logic [15:0] VEC_MONITOR = 16'hFEFC;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_REQ,
    ST_BREAK
  } abp_state_e;

endpackage

/* rtl/abp_breakpoint_unit.sv */
// Behaviour
// - Enabled break requests core when bus address equals 16-bit break address.
// - Core loads software interrupt, fetches user or monitor vector.
// - Match on last instruction cycle starts break immediately.
// - Software writing one to break active bit raises a break.
// - Match sets break active bit; software clears it with zero.
// - Break enable is bit 7, read/write, cleared by zero and reset.
// - Return from interrupt inside break routine ends break state.
// - Both timer counters halt while break is in effect.
// - Watchdog disabled during break when test voltage on reset pin.
// - High and low break address bytes, 8 bits, reset cleared.
// - Break wait flag set on wait exit by break; zero clears.
// - Break wakes part from stop and sets stop/wait-exit flag.
// - Flag clearing elsewhere during break only when clear enable set.
// - Registers remain accessible during break.
// - Break logic keeps matching during wait mode.
module abp_breakpoint_unit
  import abp_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        srst_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  input  wire logic [15:0] cpu_addr_in,
  input  wire logic        cpu_addr_valid_in,
  input  wire logic        cpu_last_cycle_in,
  input  wire logic        cpu_break_ack_in,
  input  wire logic        cpu_return_in,
  input  wire logic        cpu_wait_in,
  input  wire logic        cpu_stop_in,
  input  wire logic        monitor_mode_in,
  input  wire logic        test_level_in,
  output logic             break_req_out,
  output logic             break_now_out,
  output logic      [15:0] break_vector_out,
  output logic             break_state_out,
  output logic             timer_halt_out,
  output logic             watchdog_disable_out,
  output logic             flag_clear_allow_out,
  output logic             wake_out,
  output logic             irq_out
);

  function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] off);
    wr_hit = wr && (a == off);
  endfunction

  abp_state_e  state_q;
  abp_state_e  state_d;
  logic        enable_q;
  logic        active_q;
  logic [7:0]  bp_high_q;
  logic [7:0]  bp_low_q;
  logic        wait_exit_q;
  logic        low_power_exit_q;
  logic        clear_in_break_q;
  logic [2:0]  irq_stat_q;
  logic [2:0]  irq_mask_q;
  logic        tst_meta_q;
  logic        tst_sync_q;
  logic        addr_match;
  logic        sw_trig;
  logic        trigger;
  logic        wr_scr;
  logic        wr_wake;
  logic        wr_irq;

  assign addr_match = enable_q && cpu_addr_valid_in && (cpu_addr_in == {bp_high_q, bp_low_q});
  assign wr_scr     = wr_hit(reg_wr_in, reg_addr_in, OFF_BREAK_STATUS_CONTROL);
  assign wr_wake    = wr_hit(reg_wr_in, reg_addr_in, OFF_BREAK_WAKE_STATUS);
  assign wr_irq     = wr_hit(reg_wr_in, reg_addr_in, OFF_IRQ_STATUS);
  assign sw_trig    = wr_scr && reg_wdata_in[BIT_BREAK_ACTIVE];
  assign trigger    = (state_q == ST_IDLE) && (addr_match || sw_trig);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (trigger) begin
          state_d = ST_REQ;
        end
      end
      ST_REQ: begin
        if (cpu_break_ack_in) begin
          state_d = ST_BREAK;
        end
      end
      ST_BREAK: begin
        if (cpu_return_in) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Core-facing outputs, all registered
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      break_req_out        <= 1'b0;
      break_now_out        <= 1'b0;
      break_state_out      <= 1'b0;
      timer_halt_out       <= 1'b0;
      watchdog_disable_out <= 1'b0;
      flag_clear_allow_out <= 1'b1;
      break_vector_out     <= VEC_USER;
    end else begin
      break_req_out        <= (state_d == ST_REQ);
      break_now_out        <= trigger && addr_match && cpu_last_cycle_in;
      break_state_out      <= (state_d == ST_BREAK);
      timer_halt_out       <= (state_d == ST_BREAK);
      watchdog_disable_out <= (state_d == ST_BREAK) && tst_sync_q;
      flag_clear_allow_out <= (state_d != ST_BREAK) || clear_in_break_q;
      break_vector_out     <= monitor_mode_in ? VEC_MONITOR : VEC_USER;
    end
  end

  // Reset pin level comes from outside the clock domain
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      tst_meta_q <= 1'b0;
      tst_sync_q <= 1'b0;
    end else begin
      tst_meta_q <= test_level_in;
      tst_sync_q <= tst_meta_q;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      enable_q <= 1'b0;
      active_q <= 1'b0;
    end else begin
      if (wr_scr) begin
        enable_q <= reg_wdata_in[BIT_BREAK_ENABLE];
      end
      // match sets, set wins over a clearing write
      if (addr_match) begin
        active_q <= 1'b1;
      end else if (wr_scr) begin
        active_q <= reg_wdata_in[BIT_BREAK_ACTIVE];
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      bp_high_q <= RST_BYTE;
      bp_low_q  <= RST_BYTE;
    end else begin
      if (wr_hit(reg_wr_in, reg_addr_in, OFF_BREAK_ADDRESS_HIGH)) begin
        bp_high_q <= reg_wdata_in;
      end
      if (wr_hit(reg_wr_in, reg_addr_in, OFF_BREAK_ADDRESS_LOW)) begin
        bp_low_q <= reg_wdata_in;
      end
    end
  end

  // Wake handling; a set in the clearing cycle wins
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      wait_exit_q      <= 1'b0;
      low_power_exit_q <= 1'b0;
      wake_out         <= 1'b0;
    end else begin
      wake_out <= trigger && (cpu_wait_in || cpu_stop_in);
      if (trigger && cpu_wait_in) begin
        wait_exit_q <= 1'b1;
      end else if (wr_wake && !reg_wdata_in[BIT_BREAK_WAIT]) begin
        wait_exit_q <= 1'b0;
      end
      if (trigger && (cpu_wait_in || cpu_stop_in)) begin
        low_power_exit_q <= 1'b1;
      end else if (wr_wake && !reg_wdata_in[BIT_STOP_WAIT_EXIT]) begin
        low_power_exit_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      clear_in_break_q <= 1'b0;
    end else if (wr_hit(reg_wr_in, reg_addr_in, OFF_BREAK_FLAG_CLEAR_CONTROL)) begin
      clear_in_break_q <= reg_wdata_in[BIT_CLEAR_FLAGS_EN];
    end
  end

  // Sticky event bits, write one to clear, set wins
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      irq_stat_q <= RST_IRQ;
      irq_mask_q <= RST_IRQ;
      irq_out    <= 1'b0;
    end else begin
      irq_stat_q[BIT_EV_MATCH] <= (trigger && addr_match)
        || (irq_stat_q[BIT_EV_MATCH] && !(wr_irq && reg_wdata_in[BIT_EV_MATCH]));
      irq_stat_q[BIT_EV_SOFTWARE] <= (trigger && !addr_match)
        || (irq_stat_q[BIT_EV_SOFTWARE] && !(wr_irq && reg_wdata_in[BIT_EV_SOFTWARE]));
      irq_stat_q[BIT_EV_WAKE] <= (trigger && (cpu_wait_in || cpu_stop_in))
        || (irq_stat_q[BIT_EV_WAKE] && !(wr_irq && reg_wdata_in[BIT_EV_WAKE]));
      if (wr_hit(reg_wr_in, reg_addr_in, OFF_IRQ_MASK)) begin
        irq_mask_q <= reg_wdata_in[2:0];
      end
      // One cycle behind status so the output stays a flop
      irq_out <= |(irq_stat_q & irq_mask_q);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      reg_rdata_out <= RST_BYTE;
    end else if (!reg_rd_in) begin
      reg_rdata_out <= RST_BYTE;
    end else if (reg_addr_in == OFF_BREAK_STATUS_CONTROL) begin
      reg_rdata_out <= {enable_q, active_q, 6'h00};
    end else if (reg_addr_in == OFF_BREAK_ADDRESS_HIGH) begin
      reg_rdata_out <= bp_high_q;
    end else if (reg_addr_in == OFF_BREAK_ADDRESS_LOW) begin
      reg_rdata_out <= bp_low_q;
    end else if (reg_addr_in == OFF_BREAK_WAKE_STATUS) begin
      reg_rdata_out <= {6'h00, wait_exit_q, low_power_exit_q};
    end else if (reg_addr_in == OFF_BREAK_FLAG_CLEAR_CONTROL) begin
      reg_rdata_out <= {clear_in_break_q, 7'h00};
    end else if (reg_addr_in == OFF_IRQ_STATUS) begin
      reg_rdata_out <= {5'h00, irq_stat_q};
    end else if (reg_addr_in == OFF_IRQ_MASK) begin
      reg_rdata_out <= {5'h00, irq_mask_q};
    end else begin
      reg_rdata_out <= RST_BYTE;
    end
  end

  property p_req_on_match;
    @(posedge mclk_in) disable iff (srst_in)
      (state_q == ST_IDLE && enable_q && cpu_addr_valid_in
       && cpu_addr_in == {bp_high_q, bp_low_q}) |=> break_req_out;
  endproperty
  a_req_on_match: assert property (p_req_on_match)
    else $error("address match gave no break request");

  property p_vector;
    @(posedge mclk_in) disable iff (srst_in)
      $rose(break_req_out) |->
        break_vector_out == ($past(monitor_mode_in) ? VEC_MONITOR : VEC_USER);
  endproperty
  a_vector: assert property (p_vector)
    else $error("wrong break vector for mode");

  property p_now;
    @(posedge mclk_in) disable iff (srst_in)
      (trigger && addr_match && cpu_last_cycle_in) |=> break_now_out && break_req_out;
  endproperty
  a_now: assert property (p_now)
    else $error("final cycle match did not start break at once");

  property p_sw_break;
    @(posedge mclk_in) disable iff (srst_in)
      (state_q == ST_IDLE && reg_wr_in && reg_addr_in == OFF_BREAK_STATUS_CONTROL
       && reg_wdata_in[BIT_BREAK_ACTIVE]) |=> break_req_out ##0 irq_stat_q != 3'h0;
  endproperty
  a_sw_break: assert property (p_sw_break)
    else $error("software write did not raise break");

  property p_active_set;
    @(posedge mclk_in) disable iff (srst_in)
      addr_match |=> active_q;
  endproperty
  a_active_set: assert property (p_active_set)
    else $error("active bit not set on match");

  property p_enable_clear;
    @(posedge mclk_in) disable iff (srst_in)
      (reg_wr_in && reg_addr_in == OFF_BREAK_STATUS_CONTROL
       && !reg_wdata_in[BIT_BREAK_ENABLE]) |=> !enable_q ##1 !break_now_out;
  endproperty
  a_enable_clear: assert property (p_enable_clear)
    else $error("enable bit not cleared by zero write");

  property p_return_ends;
    @(posedge mclk_in) disable iff (srst_in)
      (break_state_out && cpu_return_in) |=> !break_state_out && !timer_halt_out;
  endproperty
  a_return_ends: assert property (p_return_ends)
    else $error("return did not end break state");

  property p_timer_halt;
    @(posedge mclk_in) disable iff (srst_in)
      $rose(break_state_out) |-> timer_halt_out && $past(break_req_out);
  endproperty
  a_timer_halt: assert property (p_timer_halt)
    else $error("timers not halted in break");

  property p_watchdog;
    @(posedge mclk_in) disable iff (srst_in)
      (state_q == ST_BREAK && cpu_return_in == 1'b0 && tst_sync_q) |=> watchdog_disable_out;
  endproperty
  a_watchdog: assert property (p_watchdog)
    else $error("watchdog not disabled under test level");

  property p_wait_flag;
    @(posedge mclk_in) disable iff (srst_in)
      (trigger && cpu_wait_in) |=> wait_exit_q && low_power_exit_q && wake_out;
  endproperty
  a_wait_flag: assert property (p_wait_flag)
    else $error("wait exit flag not set");

  property p_stop_flag;
    @(posedge mclk_in) disable iff (srst_in)
      (trigger && cpu_stop_in) |=> low_power_exit_q && wake_out;
  endproperty
  a_stop_flag: assert property (p_stop_flag)
    else $error("stop exit flag not set");

  property p_flag_gate;
    @(posedge mclk_in) disable iff (srst_in)
      (break_state_out && !clear_in_break_q && !cpu_return_in) |=> !flag_clear_allow_out;
  endproperty
  a_flag_gate: assert property (p_flag_gate)
    else $error("flag clearing allowed in break without enable");

  property p_req_hold;
    @(posedge mclk_in) disable iff (srst_in)
      (break_req_out && !cpu_break_ack_in) |=> break_req_out;
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("break request dropped before acknowledge");

endmodule

/* sim/abp_core_model.sv */
module abp_core_model
  import abp_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        srst_in,
  input  wire logic        break_req_in,
  input  wire logic        break_state_in,
  input  wire logic [15:0] break_vector_in,
  input  wire logic [3:0]  ack_delay_in,
  input  wire logic        return_go_in,
  output logic             break_ack_out,
  output logic             return_out,
  output logic      [15:0] fetched_vector_out
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] wait_q;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      break_ack_out      <= 1'h0;
      wait_q             <= 4'h0;
      fetched_vector_out <= 16'h0000;
    end else begin
      break_ack_out <= 1'h0;
      if (break_req_in && !break_ack_out) begin
        if (wait_q == ack_delay_in) begin
          break_ack_out      <= 1'h1;
          fetched_vector_out <= break_vector_in;
          wait_q             <= 4'h0;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    return_out <= !srst_in && return_go_in && break_state_in;
  end
endmodule

/* sim/test_abp_breakpoint_unit.sv */
module test_abp_breakpoint_unit
  import abp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        mclk_in, srst_in, reg_wr_in, reg_rd_in, cpu_addr_valid_in, cpu_last_cycle_in;
  logic        cpu_break_ack_in, cpu_return_in, cpu_wait_in, cpu_stop_in, monitor_mode_in;
  logic        test_level_in, break_req_out, break_now_out, break_state_out, timer_halt_out;
  logic        watchdog_disable_out, flag_clear_allow_out, wake_out, irq_out, ret_go;
  logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out;
  logic [15:0] cpu_addr_in, break_vector_out, fetched;
  logic [3:0]  ack_delay;
  int          fail_count, cmp_count, cyc;

  abp_breakpoint_unit abp_breakpoint_unit_i (.mclk_in, .srst_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .cpu_addr_in, .cpu_addr_valid_in,
    .cpu_last_cycle_in, .cpu_break_ack_in, .cpu_return_in, .cpu_wait_in, .cpu_stop_in,
    .monitor_mode_in, .test_level_in, .break_req_out, .break_now_out, .break_vector_out,
    .break_state_out, .timer_halt_out, .watchdog_disable_out, .flag_clear_allow_out,
    .wake_out, .irq_out);

  abp_core_model abp_core_model_i (.mclk_in, .srst_in, .break_req_in(break_req_out),
    .break_state_in(break_state_out), .break_vector_in(break_vector_out),
    .ack_delay_in(ack_delay), .return_go_in(ret_go), .break_ack_out(cpu_break_ack_in),
    .return_out(cpu_return_in), .fetched_vector_out(fetched));

  initial begin
    mclk_in = 1'h0;
    forever #5 mclk_in = ~mclk_in;
  end

  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Run should need well under a thousand cycles
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      tally_and_finish;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'h1;
    @(posedge mclk_in);
    reg_wr_in <= 1'h0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'h1;
    @(posedge mclk_in);
    reg_rd_in <= 1'h0;
    #1 chk(reg_rdata_out, exp, what);
  endtask

  task automatic hit(input logic [15:0] a, input logic last);
    @(posedge mclk_in);
    cpu_addr_in       <= a;
    cpu_addr_valid_in <= 1'h1;
    cpu_last_cycle_in <= last;
    @(posedge mclk_in);
    cpu_addr_valid_in <= 1'h0;
    cpu_last_cycle_in <= 1'h0;
    #1;
  endtask

  task automatic wait_state(input logic v);
    int n;
    n = 0;
    while (break_state_out !== v && n < 20) begin
      @(posedge mclk_in);
      #1 n++;
    end
    chk(break_state_out, v, "break state");
  endtask

  task automatic leave_break(input logic [7:0] ctl);
    wr(OFF_BREAK_STATUS_CONTROL, ctl);
    @(posedge mclk_in);
    ret_go <= 1'h1;
    @(posedge mclk_in);
    ret_go <= 1'h0;
    wait_state(1'h0);
    chk(timer_halt_out, 1'h0, "timers run");
    chk(flag_clear_allow_out, 1'h1, "clear allowed");
  endtask

  task automatic t_reset;
    chk(flag_clear_allow_out, 1'h1, "clear allow idle");
    chk(break_vector_out, VEC_USER, "user vector");
    for (int a = 0; a < 8; a++) rd(a[7:0], RST_BYTE, "reset value");
  endtask

  task automatic t_match;
    hit(16'h1234, 1'h1);
    chk(break_req_out, 1'h0, "disabled");
    wr(OFF_BREAK_ADDRESS_HIGH, 8'h12);
    wr(OFF_BREAK_ADDRESS_LOW, 8'h34);
    rd(OFF_BREAK_ADDRESS_HIGH, 8'h12, "addr high");
    rd(OFF_BREAK_ADDRESS_LOW, 8'h34, "addr low");
    wr(OFF_BREAK_STATUS_CONTROL, 8'h80);
    wr(OFF_IRQ_MASK, 8'h01);
    hit(16'h1235, 1'h1);
    chk(break_req_out, 1'h0, "low byte differs");
    hit(16'h0234, 1'h1);
    chk(break_req_out, 1'h0, "high byte differs");
    hit(16'h1234, 1'h1);
    chk(break_req_out, 1'h1, "match request");
    chk(break_now_out, 1'h1, "start now");
    wait_state(1'h1);
    chk(break_req_out, 1'h0, "request dropped");
    chk(timer_halt_out, 1'h1, "timers halted");
    chk(flag_clear_allow_out, 1'h0, "clear blocked");
    chk(watchdog_disable_out, 1'h0, "no test level");
    chk(fetched, VEC_USER, "user vector fetch");
    rd(OFF_BREAK_STATUS_CONTROL, 8'hC0, "active set");
    rd(OFF_IRQ_STATUS, 8'h01, "match event");
    chk(irq_out, 1'h1, "irq raised");
    wr(OFF_IRQ_STATUS, 8'h01);
    @(posedge mclk_in);
    #1 chk(irq_out, 1'h0, "irq cleared");
    leave_break(8'h80);
    rd(OFF_BREAK_STATUS_CONTROL, 8'h80, "active cleared");
  endtask

  task automatic t_software;
    monitor_mode_in <= 1'h1;
    test_level_in   <= 1'h1;
    ack_delay       <= 4'h5;
    wr(OFF_BREAK_FLAG_CLEAR_CONTROL, 8'h80);
    wr(OFF_BREAK_STATUS_CONTROL, 8'h40);
    repeat (3) @(posedge mclk_in);
    #1 chk(break_req_out, 1'h1, "slow ack holds");
    chk(break_vector_out, VEC_MONITOR, "monitor vector");
    wait_state(1'h1);
    chk(fetched, VEC_MONITOR, "monitor fetch");
    chk(flag_clear_allow_out, 1'h1, "clear enabled");
    chk(watchdog_disable_out, 1'h1, "watchdog off");
    rd(OFF_IRQ_STATUS, 8'h02, "software event");
    leave_break(8'h80);
    chk(watchdog_disable_out, 1'h0, "watchdog back");
    wr(OFF_IRQ_STATUS, 8'h02);
    monitor_mode_in <= 1'h0;
    ack_delay       <= 4'h0;
  endtask

  // Stop exit leaves the wait flag alone
  task automatic t_wake(input logic stop, input logic [7:0] exp_ws);
    cpu_wait_in <= !stop;
    cpu_stop_in <= stop;
    wr(OFF_IRQ_MASK, 8'h04);
    hit(16'h1234, 1'h0);
    chk(break_req_out, 1'h1, "match in low power");
    chk(break_now_out, 1'h0, "not last cycle");
    chk(wake_out, 1'h1, "wake pulse");
    cpu_wait_in <= 1'h0;
    cpu_stop_in <= 1'h0;
    wait_state(1'h1);
    rd(OFF_BREAK_WAKE_STATUS, exp_ws, "wake flags");
    chk(irq_out, 1'h1, "wake irq");
    wr(OFF_BREAK_WAKE_STATUS, 8'h00);
    rd(OFF_BREAK_WAKE_STATUS, 8'h00, "wake flags cleared");
    wr(OFF_IRQ_STATUS, 8'h07);
    leave_break(8'h80);
  endtask

  initial begin
    {srst_in, reg_wr_in, reg_rd_in, cpu_addr_valid_in, cpu_last_cycle_in} = 5'h10;
    {cpu_wait_in, cpu_stop_in, monitor_mode_in, test_level_in, ret_go} = 5'h00;
    reg_addr_in  = 8'h00;
    reg_wdata_in = 8'h00;
    cpu_addr_in  = 16'h0000;
    ack_delay    = 4'h0;
    repeat (20) @(posedge mclk_in);
    srst_in <= 1'h0;
    @(posedge mclk_in);
    #1 t_reset;
    t_match;
    t_software;
    t_wake(1'h0, 8'h03);
    t_wake(1'h1, 8'h01);
    tally_and_finish;
  end
endmodule
